// ---- src/asrc_cfg.svh ----
// Timing and layout constants for the static memory controller.
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
`define ASRC_ADDR_W        17
`define ASRC_DATA_W        16
`define ASRC_LANE_W        8
`define ASRC_CLK_PS        25000
`define ASRC_T_ACC_PS      70000
`define ASRC_T_WP_PS       60000
`define ASRC_T_SD_PS       30000
`define ASRC_T_HZ_PS       25000
`define ASRC_ACC_CYC       ((`ASRC_T_ACC_PS + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_WP_CYC        ((`ASRC_T_WP_PS + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_HZ_CYC        ((`ASRC_T_HZ_PS + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_CNT_W         4
`endif

// ---- src/asrc_pkg.sv ----
// Types shared by the static memory controller.
package asrc_pkg;
   typedef struct packed {
      logic        write;
      logic [16:0] word_index;
      logic [15:0] wdata;
      logic [1:0]  lane_en;
   } asrc_req_t;

   typedef struct packed {
      logic        chip_sel_n;
      logic        out_en_n;
      logic        write_n;
      logic        low_lane_select_n;
      logic        high_lane_select_n;
   } asrc_ctl_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE,
      ST_WEND,
      ST_GAP
   } asrc_state_t;
endpackage

// ---- src/asrc_cnt.sv ----
// Cycle down-counter used to time each phase of an access.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_cfg.svh"
module asrc_cnt (
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   input  wire logic                   load_in,
   input  wire logic [`ASRC_CNT_W-1:0] value_in,
   output logic                        zero_out
);
   logic [`ASRC_CNT_W-1:0] cnt_ff;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= 4'h0;
      end else if (load_in) begin
         cnt_ff <= value_in;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   assign zero_out = (cnt_ff == 4'h0);
endmodule
`default_nettype wire

// ---- src/asrc_ctrl.sv ----
// Host-side controller that drives a 128K x 16 asynchronous static memory.
// Notes on behaviour
// - Write starts when all qualifiers are active, ends when one rises.
// - Write data is captured at the edge ending the write; hold it there.
// - Write strobe stays high for the whole of every read.
// - Address is valid no later than chip select falling.
// - Read data valid after access time; sample no earlier.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_cfg.svh"
module asrc_ctrl
   import asrc_pkg::*;
(
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    req_valid_in,
   input  wire asrc_req_t               req_in,
   output logic                         req_ready_out,
   output logic                         rdata_valid_out,
   output logic [`ASRC_DATA_W-1:0]      rdata_out,
   output logic [`ASRC_ADDR_W-1:0]      word_index_out,
   output asrc_ctl_t                    ctl_out,
   input  wire logic [`ASRC_DATA_W-1:0] shared_data_pins_in,
   output logic [`ASRC_DATA_W-1:0]      shared_data_pins_out,
   output logic [`ASRC_DATA_W-1:0]      shared_data_pins_oe_n_out
);
   typedef struct packed {
      asrc_state_t             st;
      asrc_ctl_t               ctl;
      logic [`ASRC_ADDR_W-1:0] addr;
      logic [`ASRC_DATA_W-1:0] wdata;
      logic                    drive;
      logic                    rvalid;
      logic [`ASRC_DATA_W-1:0] rdata;
   } asrc_state_reg_t;

   localparam asrc_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

   asrc_state_reg_t state_ff;
   asrc_state_reg_t nxt_state;
   logic            load;
   logic [`ASRC_CNT_W-1:0] load_val;
   logic            cnt_zero;

   asrc_cnt u_cnt (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .load_in  (load),
      .value_in (load_val),
      .zero_out (cnt_zero)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;
      load = 1'b0;
      load_val = 4'h0;

      case (state_ff.st)
         ST_IDLE: begin
            // The bus is parked deselected, strobes high and data released.
            nxt_state.ctl.chip_sel_n = 1'b1;
            nxt_state.ctl.out_en_n = 1'b1;
            nxt_state.ctl.write_n = 1'b1;
            nxt_state.ctl.low_lane_select_n = 1'b1;
            nxt_state.ctl.high_lane_select_n = 1'b1;
            nxt_state.drive = 1'b0;

            if (req_valid_in) begin
               // Address set in the same cycle that chip select falls.
               nxt_state.addr = req_in.word_index;
               nxt_state.ctl.chip_sel_n = 1'b0;
               nxt_state.ctl.low_lane_select_n = ~req_in.lane_en[0];
               nxt_state.ctl.high_lane_select_n = ~req_in.lane_en[1];

               load = 1'b1;

               if (req_in.write) begin
                  // Output enable held high and data driven for the whole strobe.
                  nxt_state.ctl.write_n = 1'b0;
                  nxt_state.ctl.out_en_n = 1'b1;
                  nxt_state.wdata = req_in.wdata;
                  nxt_state.drive = 1'b1;
                  load_val = 4'(`ASRC_WP_CYC);
                  nxt_state.st = ST_WRITE;
               end else begin
                  // Read keeps the write strobe high, data released.
                  nxt_state.ctl.write_n = 1'b1;
                  nxt_state.ctl.out_en_n = 1'b0;
                  nxt_state.drive = 1'b0;
                  load_val = 4'(`ASRC_ACC_CYC);
                  nxt_state.st = ST_READ;
               end
            end
         end

         ST_READ: begin
            // The strobe stays high and the host drivers stay off while reading.
            nxt_state.ctl.write_n = 1'b1;
            nxt_state.drive = 1'b0;

            if (cnt_zero) begin
               // Sample only after the access time has elapsed, lane by lane.
               if (!state_ff.ctl.low_lane_select_n) begin
                  nxt_state.rdata[7:0] = shared_data_pins_in[7:0];
               end
               if (!state_ff.ctl.high_lane_select_n) begin
                  nxt_state.rdata[15:8] = shared_data_pins_in[15:8];
               end

               nxt_state.rvalid = 1'b1;

               // Deselect at once so the memory floats its pins.
               nxt_state.ctl.chip_sel_n = 1'b1;
               nxt_state.ctl.out_en_n = 1'b1;
               nxt_state.ctl.write_n = 1'b1;
               nxt_state.ctl.low_lane_select_n = 1'b1;
               nxt_state.ctl.high_lane_select_n = 1'b1;

               load = 1'b1;
               load_val = 4'(`ASRC_HZ_CYC);
               nxt_state.st = ST_GAP;
            end
         end

         ST_WRITE: begin
            // Output enable stays high and data stays driven through the strobe.
            nxt_state.ctl.out_en_n = 1'b1;
            nxt_state.drive = 1'b1;

            if (cnt_zero) begin
               // Write strobe rises first; data and address held through it.
               nxt_state.ctl.write_n = 1'b1;
               nxt_state.st = ST_WEND;
            end
         end

         ST_WEND: begin
            // Chip select, lanes and data go one cycle after the strobe rose.
            nxt_state.ctl.chip_sel_n = 1'b1;
            nxt_state.ctl.out_en_n = 1'b1;
            nxt_state.ctl.write_n = 1'b1;
            nxt_state.ctl.low_lane_select_n = 1'b1;
            nxt_state.ctl.high_lane_select_n = 1'b1;
            nxt_state.drive = 1'b0;

            load = 1'b1;
            load_val = 4'(`ASRC_HZ_CYC);
            nxt_state.st = ST_GAP;
         end

         ST_GAP: begin
            // Bus turnaround before the next cycle may start.
            nxt_state.ctl.chip_sel_n = 1'b1;
            nxt_state.ctl.out_en_n = 1'b1;
            nxt_state.ctl.write_n = 1'b1;
            nxt_state.ctl.low_lane_select_n = 1'b1;
            nxt_state.ctl.high_lane_select_n = 1'b1;
            nxt_state.drive = 1'b0;

            if (cnt_zero) begin
               nxt_state.st = ST_IDLE;
            end
         end

         default: begin
            // An unknown state parks the bus and returns to idle.
            nxt_state.st = ST_IDLE;
            nxt_state.ctl = CTL_IDLE;
            nxt_state.drive = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff.st <= ST_IDLE;
         state_ff.ctl <= CTL_IDLE;
         state_ff.addr <= 17'h00000;
         state_ff.wdata <= 16'h0000;
         state_ff.drive <= 1'b0;
         state_ff.rvalid <= 1'b0;
         state_ff.rdata <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // The handshake output is decoded from the state register.
   assign req_ready_out = (state_ff.st == ST_IDLE);

   // Read data and its strobe come straight from flip-flops.
   assign rdata_valid_out = state_ff.rvalid;
   assign rdata_out = state_ff.rdata;

   // Every memory pin is driven from a flip-flop so no glitch reaches the device.
   assign word_index_out = state_ff.addr;
   assign ctl_out = state_ff.ctl;
   assign shared_data_pins_out = state_ff.wdata;
   assign shared_data_pins_oe_n_out = {`ASRC_DATA_W{~state_ff.drive}};
endmodule
`default_nettype wire

// ---- bench/asrc_mem_model.sv ----
// Behavioural static memory on the far side of the controller.
`timescale 1ns/1ps
`default_nettype none
module asrc_mem_model import asrc_pkg::*; (
   input  wire logic        clock_in,
   input  wire logic [16:0] idx_in,
   input  wire asrc_ctl_t   ctl_in,
   input  wire logic [15:0] pins_in,
   output logic      [15:0] pins_out,
   output logic      [1:0]  drv_out
);
   logic [15:0] mem [0:131071];
   logic [16:0] idx_dly;
   logic [15:0] fl_ff = 16'h5A3C;
   wire  [15:0] lm = {{8{drv_out[1]}}, {8{drv_out[0]}}};
   assign #70 idx_dly = idx_in;
   assign drv_out = {2{!ctl_in.chip_sel_n & ctl_in.write_n & !ctl_in.out_en_n}}
      & ~{ctl_in.high_lane_select_n, ctl_in.low_lane_select_n};
   assign pins_out = ((idx_dly === idx_in ? mem[idx_in] : fl_ff) & lm) | (fl_ff & ~lm);
   always @(posedge clock_in) fl_ff <= ~fl_ff;
   always @(posedge ctl_in.write_n) begin
      if (!ctl_in.chip_sel_n) begin
         if (!ctl_in.low_lane_select_n) mem[idx_in][7:0] = pins_in[7:0];
         if (!ctl_in.high_lane_select_n) mem[idx_in][15:8] = pins_in[15:8];
      end
   end
endmodule
`default_nettype wire

// ---- bench/asrc_ctrl_sva.sv ----
// Assertions on the controller ports.
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_sva import asrc_pkg::*; (
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        req_valid_in,
   input wire asrc_req_t   req_in,
   input wire logic        req_ready_out,
   input wire logic        rdata_valid_out,
   input wire logic [16:0] word_index_out,
   input wire asrc_ctl_t   ctl_out,
   input wire logic [15:0] shared_data_pins_out,
   input wire logic [15:0] shared_data_pins_oe_n_out
);
   asrc_req_t q_ff;
   wire rd = req_valid_in & req_ready_out & ~req_in.write & |req_in.lane_en;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) q_ff <= '0;
      else if (req_valid_in & req_ready_out) q_ff <= req_in;
   end
   a_read_answer: assert property (rd |-> ##[4:5] rdata_valid_out) else $error("late read");
   a_read_select: assert property ($fell(ctl_out.chip_sel_n) && ctl_out.write_n |->
      !ctl_out.out_en_n && word_index_out == q_ff.word_index
      && {ctl_out.high_lane_select_n, ctl_out.low_lane_select_n} == ~q_ff.lane_en) else $error("bad read");
   a_write_setup: assert property ($fell(ctl_out.chip_sel_n) && !ctl_out.write_n |->
      shared_data_pins_out == q_ff.wdata && word_index_out == q_ff.word_index) else $error("bad write");
   a_write_pulse: assert property ($fell(ctl_out.write_n) |-> !ctl_out.write_n [*4] ##1
      ctl_out.write_n) else $error("bad pulse");
   a_data_hold: assert property ($rose(ctl_out.write_n) |-> !ctl_out.chip_sel_n &&
      $stable(shared_data_pins_out) && shared_data_pins_oe_n_out == 16'h0000) else $error("no hold");
   a_read_strobe: assert property (!ctl_out.chip_sel_n && !q_ff.write |-> ctl_out.write_n)
      else $error("strobe in read");
   a_idle_deselect: assert property (req_ready_out |-> ctl_out.chip_sel_n
      && &shared_data_pins_oe_n_out) else $error("idle busy");
   a_no_contention: assert property (!ctl_out.out_en_n && ctl_out.write_n
      |-> &shared_data_pins_oe_n_out) else $error("contention");
endmodule
bind asrc_ctrl asrc_ctrl_sva u_sva (.clock_in, .rst_in, .req_valid_in, .req_in, .req_ready_out,
   .rdata_valid_out, .word_index_out, .ctl_out, .shared_data_pins_out, .shared_data_pins_oe_n_out);
`default_nettype wire

// ---- bench/asrc_ctrl_tb_top.sv ----
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_tb_top import asrc_pkg::*; ;
   logic        clock_in = 1'b0, rst_in = 1'b1, vld = 1'b0, rdy, rv;
   asrc_req_t   req = '0;
   asrc_ctl_t   ctl;
   logic [16:0] idx;
   logic [15:0] rdat, hq, hoe_n, mq, pins;
   logic [1:0]  mdrv;
   int          err_count = 0, comparisons = 0;
   assign pins = (hoe_n & mq) | (~hoe_n & hq);
   asrc_ctrl DUT (.clock_in, .rst_in, .req_valid_in(vld), .req_in(req), .req_ready_out(rdy),
      .rdata_valid_out(rv), .rdata_out(rdat), .word_index_out(idx), .ctl_out(ctl),
      .shared_data_pins_in(pins), .shared_data_pins_out(hq), .shared_data_pins_oe_n_out(hoe_n));
   asrc_mem_model u_mem (.clock_in, .idx_in(idx), .ctl_in(ctl), .pins_in(pins), .pins_out(mq),
      .drv_out(mdrv));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] l);
      int n;
      n = 0;
      @(posedge clock_in);
      #1 req = '{w, a, d, l};
      vld = 1'b1;
      do @(posedge clock_in); while (rdy !== 1'b1 && n++ < 20);
      if (rdy !== 1'b1) err_count++;
      #1 vld = 1'b0;
   endtask
   task automatic rd(input logic [16:0] a, input logic [1:0] l, input logic [15:0] e);
      int n;
      n = 0;
      xfer(1'b0, a, 16'h0000, l);
      do @(posedge clock_in); while (rv !== 1'b1 && n++ < 8);
      if (rv !== 1'b1) err_count++;
      check(rdat & {{8{l[1]}}, {8{l[0]}}}, e);
   endtask
   task automatic t_lanes;
      xfer(1'b1, 17'h00005, 16'h1234, 2'b11);
      xfer(1'b1, 17'h00005, 16'hFFCD, 2'b01);
      xfer(1'b1, 17'h00005, 16'hEE99, 2'b10);
      xfer(1'b1, 17'h00005, 16'h0000, 2'b00);
      rd(17'h00005, 2'b11, 16'hEECD);
      rd(17'h00005, 2'b01, 16'h00CD);
      rd(17'h00005, 2'b10, 16'hEE00);
   endtask
   task automatic t_edges;
      xfer(1'b1, 17'h1FFFF, 16'hBEEF, 2'b11);
      xfer(1'b1, 17'h00000, 16'h0F0F, 2'b11);
      rd(17'h1FFFF, 2'b11, 16'hBEEF);
      rd(17'h00000, 2'b11, 16'h0F0F);
      repeat (400) @(posedge clock_in);
      rd(17'h1FFFF, 2'b11, 16'hBEEF);
   endtask
   task automatic tally_and_finish;
      $display("Mismatches %0d, compares %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(negedge clock_in) check(~hoe_n & {{8{mdrv[1]}}, {8{mdrv[0]}}}, 16'h0000);
   initial forever #12.5 clock_in = ~clock_in;
   initial begin
      #50000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge clock_in);
      #1 rst_in = 1'b0;
      t_lanes;
      t_edges;
      tally_and_finish;
   end
endmodule
`default_nettype wire
